// ### wdog_pkg.sv
package wdog_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int RAIL_COUNT = 8;
    localparam int MS_W = 21;

    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_RAILS = 5'h04;
    localparam logic [4:0] OFF_RDLY = 5'h08;
    localparam logic [4:0] OFF_PWID = 5'h0C;
    localparam logic [4:0] OFF_WINIT = 5'h10;
    localparam logic [4:0] OFF_WPER = 5'h14;
    localparam logic [4:0] OFF_KICK = 5'h18;
    localparam logic [4:0] OFF_STAT = 5'h1C;

    localparam logic [4:0] RST_CTRL = 5'h08;
    localparam logic [7:0] RST_RAILS = 8'hFF;
    localparam logic [4:0] RST_RDLY = 5'h00;
    localparam logic [15:0] RST_PWID = 16'h0001;
    localparam logic [3:0] RST_WINIT = 4'h0;
    localparam logic [15:0] RST_WPER = 16'h03E8;

    localparam logic [4:0] RDLY_MAX = 5'h10;
    localparam logic [15:0] MS_MIN = 16'h0001;
    localparam logic [15:0] MS_MAX = 16'h7E00;
    localparam logic [20:0] WINIT_BASE = 21'h000064;

    // control word, bit 0 at the bottom
    typedef struct packed {
        logic track;
        logic pinEn;
        logic wdRst;
        logic wdEn;
        logic pulse;
    } ctrl_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef enum logic [2:0] {
        RS_HOLD, RS_DELAY, RS_PULSE, RS_RUN, RS_OFFDLY, RS_RECOV, RS_TRACK
    } rst_state_t;

    typedef enum logic [1:0] {WD_OFF, WD_INIT, WD_RUN, WD_TRIP} wd_state_t;
endpackage

// ### system_reset_and_watchdog.sv
`timescale 1ns/100ps
// What this block does
// R1 - In level mode reset stays asserted until the selected rails are good, then a delay.
// R2 - The reset delay is 0 ms or 1 ms doubling up to 32.8 s.
// R3 - Level mode releases on good and reasserts a delay after good is lost.
// R4 - Pulse mode emits one pulse of 1 ms to 32256 ms after good plus delay.
// R5 - In level mode the first release comes only after the delay once the selected rails are good.
// R6 - The watchdog runs on its own or drives the system reset.
// R7 - Either a kick pin toggle or a kick command restarts the count.
// R8 - The kick pin and timeout pin are optional; the command alone works.
// R9 - The watchdog waits 0 ms or 100 ms doubling up to 1638 s at start.
// R10 - The timeout period is programmable from 1 ms to 32256 ms.
// R11 - A timeout raises the timeout pin or makes a system reset pulse.
// R12 - After a timeout only a kick, or a disable and re-enable, restarts the watchdog.
// R13 - A period that runs out without a kick marks the processor as dead.
// R14 - A dead processor gets a reset, released by delay or by tracking input.
// R15 - The kick pin is synchronised and each edge counts as one toggle.
module system_reset_and_watchdog #(
    parameter int RAILS = wdog_pkg::RAIL_COUNT,
    parameter int TICK_CYCLES = wdog_pkg::TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire wdog_pkg::bus_req_t busReq,
    output logic [31:0] rdata,
    input wire logic [RAILS-1:0] railGood,
    input wire logic kickPin,
    input wire logic trackIn,
    output logic sysResetN,
    output logic wdTimeout
);
    import wdog_pkg::*;
    localparam int TW = $clog2(TICK_CYCLES);
    localparam logic [TW-1:0] TLAST = TW'(TICK_CYCLES - 1);
    // millisecond tick
    logic [TW-1:0] tickCnt, next_tickCnt;
    logic msTick, next_msTick;
    always_comb begin
        next_msTick = (tickCnt == TLAST);
        next_tickCnt = next_msTick ? '0 : tickCnt + 1'b1;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tickCnt <= '0;
            msTick <= 1'b0;
        end else begin
            tickCnt <= next_tickCnt;
            msTick <= next_msTick;
        end
    end

    // pin synchronisers: bit 0 kick, bit 1 tracking input
    logic [1:0] sync1, sync2, sync3, lvl, next_lvl;
    logic kickLvl, trackLvl, pinToggle;
    assign kickLvl = lvl[0];
    assign trackLvl = lvl[1];
    always_comb begin
        next_lvl = lvl;
        for (int i = 0; i < 2; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_lvl[i] = sync3[i];
            end
        end
        pinToggle = (sync2[0] == sync3[0]) && (sync3[0] != lvl[0]); // R15
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
            sync3 <= 2'h0;
            lvl <= 2'h0;
        end else begin
            sync1 <= {trackIn, kickPin};
            sync2 <= sync1;
            sync3 <= sync2;
            lvl <= next_lvl;
        end
    end

    // configuration registers
    ctrl_t ctrl, next_ctrl;
    logic [RAILS-1:0] railMask, next_railMask;
    logic [4:0] rdly, next_rdly;
    logic [15:0] pwid, next_pwid, wper, next_wper, wIn;
    logic [3:0] winit, next_winit;
    logic [31:0] next_rdata;
    logic cmdKick, kick, allGood, wdTrip;
    rst_state_t rstState, next_rstState;
    wd_state_t wdState, next_wdState;
    logic [MS_W-1:0] rstCnt, next_rstCnt, wdCnt, next_wdCnt;
    logic [MS_W-1:0] rdlyMs, winitMs;
    logic next_sysResetN, next_wdTimeout;
    assign cmdKick = busReq.wr && (busReq.addr == OFF_KICK);
    assign kick = cmdKick || (ctrl.pinEn && pinToggle); // R7 R8
    assign allGood = &(railGood | ~railMask);
    assign rdlyMs = (rdly == 5'h00) ? '0 : (21'h1 << (rdly - 5'h01)); // R2
    assign winitMs = (winit == 4'h0) ? '0 : (WINIT_BASE << (winit - 4'h1));
    always_comb begin
        next_ctrl = ctrl;
        next_railMask = railMask;
        next_rdly = rdly;
        next_pwid = pwid;
        next_winit = winit;
        next_wper = wper;
        next_rdata = 32'h0;
        // out-of-range times clamp rather than wrap to a tiny value
        wIn = busReq.wdata[15:0];
        if (wIn < MS_MIN) begin
            wIn = MS_MIN;
        end else if (wIn > MS_MAX) begin
            wIn = MS_MAX;
        end
        if (busReq.wr) begin
            case (busReq.addr)
                OFF_CTRL: next_ctrl = ctrl_t'(busReq.wdata[4:0]);
                OFF_RAILS: next_railMask = busReq.wdata[RAILS-1:0];
                OFF_RDLY: next_rdly = (busReq.wdata[4:0] > RDLY_MAX) ?
                    RDLY_MAX : busReq.wdata[4:0];
                OFF_PWID: next_pwid = wIn;
                OFF_WINIT: next_winit = busReq.wdata[3:0];
                OFF_WPER: next_wper = wIn; // R10
                default: ;
            endcase
        end
        if (busReq.rd) begin
            case (busReq.addr)
                OFF_CTRL: next_rdata = {27'h0, ctrl};
                OFF_RAILS: next_rdata = 32'(railMask);
                OFF_RDLY: next_rdata = {27'h0, rdly};
                OFF_PWID: next_rdata = {16'h0, pwid};
                OFF_WINIT: next_rdata = {28'h0, winit};
                OFF_WPER: next_rdata = {16'h0, wper};
                OFF_STAT: next_rdata = {22'h0, trackLvl, kickLvl, allGood,
                    wdState, rstState, wdTimeout, sysResetN};
                default: next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= ctrl_t'(RST_CTRL);
            railMask <= RAILS'(RST_RAILS);
            rdly <= RST_RDLY;
            pwid <= RST_PWID;
            winit <= RST_WINIT;
            wper <= RST_WPER;
            rdata <= 32'h0;
        end else begin
            ctrl <= next_ctrl;
            railMask <= next_railMask;
            rdly <= next_rdly;
            pwid <= next_pwid;
            winit <= next_winit;
            wper <= next_wper;
            rdata <= next_rdata;
        end
    end

    // watchdog
    always_comb begin
        next_wdState = wdState;
        next_wdCnt = (msTick && wdCnt != '0) ? wdCnt - 1'b1 : wdCnt;
        wdTrip = 1'b0;
        if (!ctrl.wdEn) begin
            next_wdState = WD_OFF; // R6
        end else begin
            case (wdState)
                WD_OFF: begin
                    next_wdState = WD_INIT;
                    next_wdCnt = winitMs; // R9
                end
                WD_INIT: begin
                    if (kick || wdCnt == '0) begin
                        next_wdState = WD_RUN;
                        next_wdCnt = MS_W'(wper);
                    end
                end
                WD_RUN: begin
                    if (kick) begin
                        next_wdCnt = MS_W'(wper); // R7
                    end else if (wdCnt == '0) begin
                        next_wdState = WD_TRIP; // R13
                        wdTrip = 1'b1;
                    end
                end
                WD_TRIP: begin
                    if (kick) begin
                        next_wdState = WD_RUN; // R12
                        next_wdCnt = MS_W'(wper);
                    end
                end
                default: next_wdState = WD_OFF;
            endcase
        end
        next_wdTimeout = (next_wdState == WD_TRIP) && !ctrl.wdRst; // R11
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wdState <= WD_OFF;
            wdCnt <= '0;
            wdTimeout <= 1'b0;
        end else begin
            wdState <= next_wdState;
            wdCnt <= next_wdCnt;
            wdTimeout <= next_wdTimeout;
        end
    end

    // system reset sequencer
    always_comb begin
        next_rstState = rstState;
        next_rstCnt = (msTick && rstCnt != '0) ? rstCnt - 1'b1 : rstCnt;
        case (rstState)
            RS_HOLD: begin
                if (allGood) begin
                    next_rstState = RS_DELAY; // R1
                    next_rstCnt = rdlyMs;
                end
            end
            RS_DELAY: begin
                if (!allGood) begin
                    next_rstState = RS_HOLD;
                end else if (rstCnt == '0) begin
                    next_rstState = ctrl.pulse ? RS_PULSE : RS_RUN; // R5
                    next_rstCnt = MS_W'(pwid); // R4
                end
            end
            RS_PULSE: begin
                if (rstCnt == '0) begin
                    next_rstState = RS_RUN;
                end
            end
            RS_RUN: begin
                if (!allGood) begin
                    next_rstState = ctrl.pulse ? RS_HOLD : RS_OFFDLY; // R3
                    next_rstCnt = rdlyMs;
                end
            end
            RS_OFFDLY: begin
                if (allGood) begin
                    next_rstState = RS_RUN;
                end else if (rstCnt == '0) begin
                    next_rstState = RS_HOLD; // R3
                end
            end
            RS_RECOV: begin
                if (rstCnt == '0) begin
                    next_rstState = ctrl.track ? RS_TRACK : RS_DELAY; // R14
                    next_rstCnt = rdlyMs;
                end
            end
            RS_TRACK: begin
                // release waits for the tracked input, then the delay
                if (trackLvl) begin
                    next_rstState = RS_DELAY; // R14
                    next_rstCnt = rdlyMs;
                end
            end
            default: next_rstState = RS_HOLD;
        endcase
        if (wdTrip && ctrl.wdRst) begin
            next_rstState = RS_RECOV; // R11 R14
            next_rstCnt = MS_W'(pwid);
        end
        next_sysResetN = !((next_rstState inside {RS_PULSE, RS_RECOV,
            RS_TRACK}) || (!ctrl.pulse &&
            (next_rstState inside {RS_HOLD, RS_DELAY})));
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rstState <= RS_HOLD;
            rstCnt <= '0;
            sysResetN <= 1'b0;
        end else begin
            rstState <= next_rstState;
            rstCnt <= next_rstCnt;
            sysResetN <= next_sysResetN;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    a_hold_until_good: assert property ( // R1
        rstState == RS_HOLD && !allGood |=> rstState != RS_DELAY)
        else $error("reset left hold without good rails");
    a_delay_expiry: assert property ( // R2
        rstState == RS_DELAY && allGood && rstCnt == '0 && !wdTrip
        |=> rstState inside {RS_PULSE, RS_RUN})
        else $error("reset delay did not end at zero");
    a_level_run_high: assert property ( // R3
        rstState == RS_RUN |-> sysResetN)
        else $error("reset asserted while running");
    a_pulse_low: assert property ( // R4
        rstState == RS_PULSE |-> !sysResetN)
        else $error("reset pulse not driven");
    a_release_cause: assert property ( // R5
        $rose(sysResetN) |-> $past(rstState inside {RS_DELAY, RS_PULSE,
        RS_TRACK, RS_RECOV} || ctrl.pulse))
        else $error("reset released without a delay");
    a_wd_disabled: assert property ( // R6
        !ctrl.wdEn |=> wdState == WD_OFF)
        else $error("watchdog ran while disabled");
    a_kick_reload: assert property ( // R7
        kick && ctrl.wdEn && wdState == WD_RUN && !busReq.wr
        |=> wdCnt == MS_W'(wper) && wdState == WD_RUN)
        else $error("kick did not reload the count");
    a_cmd_restart: assert property ( // R8
        cmdKick && ctrl.wdEn && wdState == WD_TRIP |=> wdState == WD_RUN)
        else $error("command kick did not restart");
    a_init_load: assert property ( // R9
        wdState == WD_OFF && ctrl.wdEn && !busReq.wr
        |=> wdState == WD_INIT && wdCnt == winitMs)
        else $error("initial wait not loaded");
    a_period_trip: assert property ( // R10
        wdState == WD_RUN && ctrl.wdEn && wdCnt == '0 && !kick
        |=> wdState == WD_TRIP)
        else $error("period expiry missed");
    a_timeout_pin: assert property ( // R11
        wdState == WD_TRIP && !$past(ctrl.wdRst) |-> wdTimeout)
        else $error("timeout pin not raised");
    a_trip_stays: assert property ( // R12
        wdState == WD_TRIP && ctrl.wdEn && !kick |=> wdState == WD_TRIP)
        else $error("watchdog left timeout without kick");
    a_recover_reset: assert property ( // R14
        wdTrip && ctrl.wdRst |=> rstState == RS_RECOV ##0 !sysResetN)
        else $error("timeout did not reset the processor");
    a_edge_counts: assert property ( // R15
        pinToggle |=> kickLvl != $past(kickLvl))
        else $error("kick edge not taken");
    c_released: cover property (rstState == RS_DELAY ##1 rstState == RS_RUN);
    c_pulse: cover property (rstState == RS_PULSE);
    c_trip: cover property (wdState == WD_TRIP ##[1:5] wdState == WD_RUN);
    c_recover: cover property (rstState == RS_RECOV ##1 rstState == RS_TRACK);
endmodule

// ### host_model.sv
`timescale 1ns/100ps
// processor side: toggles the kick pin while it runs and is told to
module host_model #(
    parameter int GAP = 6
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic kickOn,
    input wire logic sysResetN,
    output logic kickPin
);
    int cnt;

    // a processor held in reset cannot kick
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            kickPin <= 1'b0;
        end else if (kickOn && sysResetN) begin
            // each level lasts GAP cycles, wider than the synchroniser needs
            if (cnt == GAP - 1) begin
                cnt <= 0;
                kickPin <= ~kickPin;
            end else begin
                cnt <= cnt + 1;
            end
        end else begin
            cnt <= 0;
        end
    end
endmodule

// ### testbench.sv
`timescale 1ns/100ps
module testbench;
    import wdog_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    bus_req_t busReq = '0;
    logic [31:0] rdata;
    logic [7:0] railGood = 8'h00;
    logic kickPin;
    logic trackIn = 1'b0;
    logic kickOn = 1'b0;
    logic sysResetN;
    logic wdTimeout;
    logic hit;
    logic [31:0] v;
    int bad_count = 0;
    int checks = 0;
    int n;
    logic [4:0] tAddr [7] = '{OFF_CTRL, OFF_RAILS, OFF_RDLY, OFF_PWID,
        OFF_WINIT, OFF_WPER, 5'h02};
    logic [31:0] tExp [7] = '{32'(RST_CTRL), 32'(RST_RAILS), 32'(RST_RDLY),
        32'(RST_PWID), 32'(RST_WINIT), 32'(RST_WPER), 32'h0};

    always #20 mclk = ~mclk;

    // one ms is four cycles so the long counts stay short
    system_reset_and_watchdog #(.RAILS(8), .TICK_CYCLES(4))
        system_reset_and_watchdog_inst (
        .mclk(mclk),
        .nrst(nrst),
        .busReq(busReq),
        .rdata(rdata),
        .railGood(railGood),
        .kickPin(kickPin),
        .trackIn(trackIn),
        .sysResetN(sysResetN),
        .wdTimeout(wdTimeout)
    );

    host_model host_model_inst (
        .mclk(mclk),
        .nrst(nrst),
        .kickOn(kickOn),
        .sysResetN(sysResetN),
        .kickPin(kickPin)
    );

    task automatic conclude();
        if (bad_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cmpRange(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("mismatch at %0t: got %0h expected %0h..%0h", $time, got,
                lo, hi);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        busReq.wr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge mclk);
        busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        busReq.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // which 0 watches sysResetN, 1 watches wdTimeout
    task automatic waitFor(input int which, input logic lvl, input int bound,
        output int cyc);
        cyc = 0;
        while (((which == 0) ? sysResetN : wdTimeout) !== lvl) begin
            @(posedge mclk);
            #1;
            cyc++;
            if (cyc > bound) begin
                cmpRange(cyc, 0, bound);
                conclude();
            end
        end
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        cmpVal(sysResetN, 32'h0);
        for (int i = 0; i < 7; i++) begin
            rd(tAddr[i], v);
            cmpVal(v, tExp[i]);
        end
        wr(5'h02, 32'hFFFFFFFF);
        rd(5'h02, v);
        cmpVal(v, 32'h0);
        wr(OFF_PWID, 32'h0);
        rd(OFF_PWID, v);
        cmpVal(v, 32'h1);
        wr(OFF_WPER, 32'hFFFF);
        rd(OFF_WPER, v);
        cmpVal(v, 32'h7E00);
        wr(OFF_RDLY, 32'h1F);
        rd(OFF_RDLY, v);
        cmpVal(v, 32'h10);
        // level mode, rails 0..3 required, 4 ms delay
        wr(OFF_RAILS, 32'h0F);
        wr(OFF_RDLY, 32'h3);
        @(posedge mclk) railGood <= 8'h0F;
        waitFor(0, 1'b1, 40, n);
        cmpRange(n, 12, 22);
        @(posedge mclk) railGood <= 8'h07;
        waitFor(0, 1'b0, 40, n);
        cmpRange(n, 12, 22);
        wr(OFF_RDLY, 32'h0);
        wr(OFF_PWID, 32'h2);
        wr(OFF_CTRL, 32'h09);
        @(posedge mclk) railGood <= 8'h00;
        repeat (4) @(posedge mclk);
        cmpVal(sysResetN, 32'h1);
        @(posedge mclk) railGood <= 8'h0F;
        waitFor(0, 1'b0, 40, n);
        cmpRange(n, 0, 8);
        waitFor(0, 1'b1, 40, n);
        cmpRange(n, 4, 12);
        wr(OFF_CTRL, 32'h08);
        waitFor(0, 1'b1, 20, n);
        // pin kicks keep a 3 ms period alive
        wr(OFF_WPER, 32'h3);
        wr(OFF_CTRL, 32'h0A);
        kickOn <= 1'b1;
        hit = 1'b0;
        repeat (300) begin
            @(posedge mclk);
            if (wdTimeout !== 1'b0) hit = 1'b1;
        end
        cmpVal(hit, 32'h0);
        kickOn <= 1'b0;
        waitFor(1, 1'b1, 40, n);
        cmpRange(n, 4, 30);
        cmpVal(sysResetN, 32'h1);
        rd(OFF_STAT, v);
        cmpVal(v & 32'h62, 32'h62);
        repeat (40) @(posedge mclk);
        cmpVal(wdTimeout, 32'h1);
        wr(OFF_KICK, 32'h1);
        waitFor(1, 1'b0, 4, n);
        cmpRange(n, 0, 3);
        // pin kicks disabled: only the command counts
        wr(OFF_CTRL, 32'h02);
        kickOn <= 1'b1;
        waitFor(1, 1'b1, 40, n);
        cmpRange(n, 0, 30);
        repeat (10) begin
            wr(OFF_KICK, 32'h1);
            repeat (4) @(posedge mclk);
        end
        cmpVal(wdTimeout, 32'h0);
        kickOn <= 1'b0;
        // 100 ms initial wait, then one 3 ms period
        wr(OFF_CTRL, 32'h08);
        wr(OFF_WINIT, 32'h1);
        wr(OFF_CTRL, 32'h0A);
        waitFor(1, 1'b1, 500, n);
        cmpRange(n, 396, 440);
        // timeout drives a reset pulse instead of the pin
        wr(OFF_CTRL, 32'h08);
        wr(OFF_WINIT, 32'h0);
        wr(OFF_WPER, 32'h2);
        wr(OFF_RDLY, 32'h1);
        wr(OFF_CTRL, 32'h06);
        waitFor(0, 1'b0, 40, n);
        cmpRange(n, 4, 16);
        cmpVal(wdTimeout, 32'h0);
        waitFor(0, 1'b1, 40, n);
        cmpRange(n, 8, 20);
        // release waits for the tracking input
        wr(OFF_CTRL, 32'h08);
        wr(OFF_CTRL, 32'h16);
        waitFor(0, 1'b0, 40, n);
        repeat (40) @(posedge mclk);
        cmpVal(sysResetN, 32'h0);
        @(posedge mclk) trackIn <= 1'b1;
        waitFor(0, 1'b1, 20, n);
        cmpRange(n, 2, 14);
        conclude();
    end
endmodule
